/* rtl/spi_cmd_pkg.sv */
// Constants shared by the serial direct command interpreter and its FIFO.
// Summary of operation
// - Code 0x00 acts like power-on reset and reloads calibration from nonvolatile memory.
// - Code 0x01 converts temperature; 16 clocks return six zeros then 10-bit result.
// - Codes 0x02-0x04 convert battery, sensor 1, sensor 2; read out like temperature.
// - Code 0x05 issues one log-start pulse; start time stored earlier by master.
// - Code 0x06 stops logging and issues one log-stop pulse.
// - Code 0x07 returns the eight-bit FIFO status byte.
// - Code 0x08 returns the 24-bit remaining shelf life value.
// - Code 0x20 reads one to eight bytes from the shared FIFO in one frame.
// - Code 0x21 writes one to eight bytes into the shared FIFO in one frame.
// - One eight-byte FIFO is shared by serial port and radio side.
// - Status bit 7 busy, bit 6 data ready, bit 5 no data.
// - Status bit 4 is 0 for serial-written data, 1 for radio-written data.
// - Status bits 3 to 0 give valid byte count, 0 to 8.
// - Radio side reaches FIFO contents and status through one access command.
// - While serial select is high, radio memory or FIFO commands get an error.
// - Radio using FIFO at select rise: data out goes high, serial commands ignored.
// - With delay mode set, a log start waits for the button on data input.
// - Alternatively logging begins after a programmed fixed delay from log start.
// - Shelf life expiry drives excitation pad as alarm unless sensor supply selected.
// - Frame starts with two mode bits; 11 selects direct command with six-bit code.
// - Memory access priority: radio first, logger second, serial port last.
// - Serial data output is always actively driven, never high impedance.
package spi_cmd_pkg;
    // Frame header
    localparam logic [1:0] MODE_DIRECT = 2'h3;
    localparam logic [5:0] CMD_RESET = 6'h00;
    localparam logic [5:0] CMD_GET_TEMP = 6'h01;
    localparam logic [5:0] CMD_GET_BATT = 6'h02;
    localparam logic [5:0] CMD_GET_EXT1 = 6'h03;
    localparam logic [5:0] CMD_GET_EXT2 = 6'h04;
    localparam logic [5:0] CMD_START_LOG = 6'h05;
    localparam logic [5:0] CMD_STOP_LOG = 6'h06;
    localparam logic [5:0] CMD_FIFO_STATUS = 6'h07;
    localparam logic [5:0] CMD_SHELF_LIFE = 6'h08;
    localparam logic [5:0] CMD_READ_FIFO = 6'h20;
    localparam logic [5:0] CMD_WRITE_FIFO = 6'h21;
    // Readout lengths in serial clocks
    localparam logic [4:0] LEN_CONV = 5'h10;
    localparam logic [4:0] LEN_STATUS = 5'h08;
    localparam logic [4:0] LEN_SHELF = 5'h18;
    localparam logic [5:0] CONV_PAD = 6'h00;
    // FIFO shape
    localparam int FIFO_DEPTH = 8;
    localparam logic [3:0] FIFO_FULL_CNT = 4'h8;
    // Status byte fields
    localparam int STAT_BUSY = 7;
    localparam int STAT_READY = 6;
    localparam int STAT_EMPTY = 5;
    localparam int STAT_SRC = 4;
    localparam logic SRC_SERIAL = 1'b0;
    localparam logic SRC_RADIO = 1'b1;
    localparam logic [7:0] STATUS_RESET = 8'h20;
    // Memory arbiter grants
    localparam int GNT_RADIO = 0;
    localparam int GNT_LOGGER = 1;
    localparam int GNT_SERIAL = 2;
    // Frame states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_CMD = 3'b001,
        ST_CONV_WAIT = 3'b010,
        ST_TX = 3'b011,
        ST_RD_FIFO = 3'b100,
        ST_WR_FIFO = 3'b101,
        ST_BUSY = 3'b110,
        ST_IGNORE = 3'b111
    } frame_state_t;
endpackage

/* rtl/pin_sync.sv */
// Two-flop synchronisers for the serial pins.
module pin_sync
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic reset_i,
    // Raw pins and synchronised levels
    input wire logic [2:0] pin_i,
    output logic [2:0] pin_o
);
    genvar g;
    // One chain per pin; first stage feeds only the second
    generate
        for (g = 0; g < 3; g = g + 1)
        begin : g_sync
            logic meta_q;
            logic sync_q;
            always_ff @(posedge core_clk_i)
            begin
                if (reset_i)
                begin
                    meta_q <= 1'b0;
                    sync_q <= 1'b0;
                end
                else
                begin
                    meta_q <= pin_i[g];
                    sync_q <= meta_q;
                end
            end
            assign pin_o[g] = sync_q;
        end
    endgenerate
endmodule

/* rtl/fifo_mem.sv */
// Eight-byte storage of the shared mailbox with registered read data.
module fifo_mem
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic reset_i,
    // Write port
    input wire logic wr_en_i,
    input wire logic [2:0] wr_addr_i,
    input wire logic [7:0] wr_data_i,
    // Read port
    input wire logic [2:0] rd_addr_i,
    output logic [7:0] rd_data_o
);
    import spi_cmd_pkg::*;
    logic [7:0] mem_q [FIFO_DEPTH];
    // Store incoming byte
    always_ff @(posedge core_clk_i)
    begin
        if (wr_en_i)
        begin
            mem_q[wr_addr_i] <= wr_data_i;
        end
    end
    // Head byte always presented from a register
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            rd_data_o <= 8'h00;
        end
        else
        begin
            rd_data_o <= mem_q[rd_addr_i];
        end
    end
endmodule

/* rtl/spi_direct_command_fifo.sv */
// Serial direct command interpreter with shared mailbox FIFO and log start control.
module spi_direct_command_fifo
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic reset_i,
    // Serial pins from the master
    input wire logic serial_select_i,
    input wire logic sclk_i,
    input wire logic sdi_i,
    output logic conversion_done_out_o,
    // Calibration reload request
    output logic por_reload_o,
    // Converter
    output logic conv_start_o,
    output logic [1:0] conv_sel_o,
    input wire logic conv_done_i,
    input wire logic [9:0] conv_result_i,
    // Logging engine
    input wire logic delay_mode_i,
    input wire logic fixed_delay_en_i,
    input wire logic [31:0] log_delay_cycles_i,
    output logic log_start_o,
    output logic log_stop_o,
    output logic logging_begin_o,
    // Shelf life and excitation pad
    input wire logic [23:0] shelf_life_i,
    input wire logic shelf_algo_en_i,
    input wire logic shelf_expired_i,
    input wire logic sensor_supply_select_i,
    input wire logic sensor_conv_active_i,
    output logic excitation_pad_o,
    output logic excitation_pad_oe_o,
    // Radio side FIFO access
    input wire logic rf_fifo_active_i,
    input wire logic rf_access_cmd_i,
    input wire logic rf_fifo_wr_i,
    input wire logic [7:0] rf_fifo_wdata_i,
    input wire logic rf_fifo_rd_i,
    output logic [7:0] rf_fifo_rdata_o,
    output logic [7:0] fifo_state_byte_o,
    output logic rf_error_o,
    // Memory arbitration
    input wire logic rf_mem_req_i,
    input wire logic log_mem_req_i,
    input wire logic spi_mem_req_i,
    output logic [2:0] mem_grant_o
);
    import spi_cmd_pkg::*;
    // Synchronised pins
    logic [2:0] pins_s;
    wire sen_s = pins_s[2];
    wire sclk_s = pins_s[1];
    wire sdi_s = pins_s[0];
    pin_sync u_sync
    (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .pin_i({serial_select_i, sclk_i, sdi_i}),
        .pin_o(pins_s)
    );
    // Frame state
    frame_state_t state_q;
    frame_state_t state_d;
    logic sclk_prev_q;
    logic sen_prev_q;
    logic [7:0] rx_sh_q;
    logic [2:0] hdr_cnt_q;
    logic [23:0] tx_sh_q;
    logic [4:0] tx_cnt_q;
    logic [4:0] tx_len_q;
    logic [2:0] byte_bit_q;
    logic sdo_q;
    // Edge and frame event detection
    wire sclk_rise = sclk_s & ~sclk_prev_q;
    wire sen_rise = sen_s & ~sen_prev_q;
    wire sen_fall = ~sen_s & sen_prev_q;
    wire [7:0] hdr_byte = {rx_sh_q[6:0], sdi_s};
    wire hdr_done = (state_q == ST_CMD) && sclk_rise && (hdr_cnt_q == 3'h7);
    wire is_direct = (hdr_byte[7:6] == MODE_DIRECT);
    wire [5:0] cmd_code = hdr_byte[5:0];
    wire cmd_hit = hdr_done && is_direct;
    // Decoded command strobes
    wire do_reset = cmd_hit && (cmd_code == CMD_RESET);
    wire do_conv = cmd_hit && (cmd_code >= CMD_GET_TEMP) && (cmd_code <= CMD_GET_EXT2);
    wire do_start = cmd_hit && (cmd_code == CMD_START_LOG);
    wire do_stop = cmd_hit && (cmd_code == CMD_STOP_LOG);
    wire do_status = cmd_hit && (cmd_code == CMD_FIFO_STATUS);
    wire do_shelf = cmd_hit && (cmd_code == CMD_SHELF_LIFE);
    wire do_rd_fifo = cmd_hit && (cmd_code == CMD_READ_FIFO);
    wire do_wr_fifo = cmd_hit && (cmd_code == CMD_WRITE_FIFO);
    wire [5:0] conv_idx = cmd_code - CMD_GET_TEMP;
    // FIFO bookkeeping
    logic [2:0] wr_ptr_q;
    logic [2:0] rd_ptr_q;
    logic [3:0] count_q;
    logic src_q;
    logic [7:0] head_byte;
    wire fifo_empty = (count_q == 4'h0);
    wire fifo_full = (count_q == FIFO_FULL_CNT);
    wire spi_owns = sen_s;
    wire byte_start = (byte_bit_q == 3'h0);
    wire spi_pop = (state_q == ST_RD_FIFO) && sclk_rise && byte_start && !fifo_empty;
    wire spi_push = (state_q == ST_WR_FIFO) && sclk_rise && (byte_bit_q == 3'h7)
        && !fifo_full;
    wire rf_push = rf_fifo_wr_i && !spi_owns && !fifo_full;
    wire rf_pop = rf_fifo_rd_i && !spi_owns && !fifo_empty;
    wire fifo_wr = spi_push || rf_push;
    wire fifo_rd = spi_pop || rf_pop;
    wire [7:0] fifo_wdata = spi_push ? hdr_byte : rf_fifo_wdata_i;
    wire [7:0] tx_byte = fifo_empty ? 8'h00 : head_byte;
    wire spi_fifo_busy = (state_q == ST_RD_FIFO) || (state_q == ST_WR_FIFO);
    // Status byte assembly
    wire [7:0] status_d = {rf_fifo_active_i || spi_fifo_busy, !fifo_empty, fifo_empty,
                           src_q, count_q};
    fifo_mem u_mem
    (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .wr_en_i(fifo_wr),
        .wr_addr_i(wr_ptr_q),
        .wr_data_i(fifo_wdata),
        .rd_addr_i(rd_ptr_q),
        .rd_data_o(head_byte)
    );
    // Next frame state
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_IDLE:
                if (sen_rise)
                    state_d = rf_fifo_active_i ? ST_BUSY : ST_CMD;
            ST_CMD:
                if (hdr_done)
                begin
                    if (do_conv)
                        state_d = ST_CONV_WAIT;
                    else if (do_status || do_shelf)
                        state_d = ST_TX;
                    else if (do_rd_fifo)
                        state_d = ST_RD_FIFO;
                    else if (do_wr_fifo)
                        state_d = ST_WR_FIFO;
                    else
                        state_d = ST_IGNORE;
                end
            ST_CONV_WAIT:
                if (conv_done_i)
                    state_d = ST_TX;
            ST_TX:
                if (sclk_rise && (tx_cnt_q == tx_len_q))
                    state_d = ST_IGNORE;
            default:
                state_d = state_q; // Data phases wait for select to fall
        endcase
        if (sen_fall || !sen_s)
            state_d = ST_IDLE;
    end
    // Frame state and pin history
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            state_q <= ST_IDLE;
            sclk_prev_q <= 1'b0;
            sen_prev_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            sclk_prev_q <= sclk_s;
            sen_prev_q <= sen_s;
        end
    end
    // Header and write data capture
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i || sen_rise)
        begin
            rx_sh_q <= 8'h00;
            hdr_cnt_q <= 3'h0;
        end
        else if (sclk_rise)
        begin
            rx_sh_q <= hdr_byte;
            hdr_cnt_q <= hdr_cnt_q + 3'h1;
        end
    end
    // Byte position inside FIFO data phases
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i || hdr_done)
            byte_bit_q <= 3'h0;
        else if (sclk_rise && spi_fifo_busy)
            byte_bit_q <= byte_bit_q + 3'h1;
    end
    // Readout shifter; data changes on each serial rising edge
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            tx_sh_q <= 24'h0000_00;
            tx_cnt_q <= 5'h00;
            tx_len_q <= 5'h00;
        end
        else if (do_status)
        begin
            tx_sh_q <= {status_d, 16'h0000};
            tx_cnt_q <= 5'h00;
            tx_len_q <= LEN_STATUS;
        end
        else if (do_shelf)
        begin
            tx_sh_q <= shelf_life_i;
            tx_cnt_q <= 5'h00;
            tx_len_q <= LEN_SHELF;
        end
        else if ((state_q == ST_CONV_WAIT) && conv_done_i)
        begin
            tx_sh_q <= {CONV_PAD, conv_result_i, 8'h00};
            tx_cnt_q <= 5'h00;
            tx_len_q <= LEN_CONV;
        end
        else if (sclk_rise && (state_q == ST_TX))
        begin
            tx_sh_q <= {tx_sh_q[22:0], 1'b0};
            tx_cnt_q <= tx_cnt_q + 5'h01;
        end
        else if (sclk_rise && (state_q == ST_RD_FIFO))
            tx_sh_q <= byte_start ? {tx_byte[6:0], 17'h0_0000} : {tx_sh_q[22:0], 1'b0};
    end
    // Serial data output, always driven
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
            sdo_q <= 1'b0;
        else if ((state_d == ST_BUSY) || ((state_q == ST_CONV_WAIT) && conv_done_i))
            sdo_q <= 1'b1;
        else if (sclk_rise && (state_q == ST_TX))
            sdo_q <= (tx_cnt_q == tx_len_q) ? 1'b0 : tx_sh_q[23];
        else if (sclk_rise && (state_q == ST_RD_FIFO))
            sdo_q <= byte_start ? tx_byte[7] : tx_sh_q[23];
        else if ((state_d == ST_IDLE) || (state_d == ST_IGNORE) || hdr_done)
            sdo_q <= 1'b0;
    end
    assign conversion_done_out_o = sdo_q;
    // Pointers, count and source of the shared FIFO
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i || do_reset)
        begin
            wr_ptr_q <= 3'h0;
            rd_ptr_q <= 3'h0;
            count_q <= 4'h0;
            src_q <= SRC_SERIAL;
        end
        else
        begin
            if (fifo_wr)
            begin
                wr_ptr_q <= wr_ptr_q + 3'h1;
                src_q <= spi_push ? SRC_SERIAL : SRC_RADIO;
            end
            if (fifo_rd)
                rd_ptr_q <= rd_ptr_q + 3'h1;
            if (fifo_wr && !fifo_rd)
                count_q <= count_q + 4'h1;
            else if (fifo_rd && !fifo_wr)
                count_q <= count_q - 4'h1;
        end
    end
    // Command pulses and radio-side answers
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            por_reload_o <= 1'b0;
            conv_start_o <= 1'b0;
            conv_sel_o <= 2'h0;
            log_start_o <= 1'b0;
            log_stop_o <= 1'b0;
            rf_error_o <= 1'b0;
            rf_fifo_rdata_o <= 8'h00;
            fifo_state_byte_o <= STATUS_RESET;
        end
        else
        begin
            por_reload_o <= do_reset;
            conv_start_o <= do_conv;
            if (do_conv)
                conv_sel_o <= conv_idx[1:0];
            log_start_o <= do_start;
            log_stop_o <= do_stop;
            rf_error_o <= rf_access_cmd_i && spi_owns;
            rf_fifo_rdata_o <= head_byte;
            fifo_state_byte_o <= status_d;
        end
    end
    // Delayed log start by button or fixed delay
    logic btn_wait_q;
    logic dly_wait_q;
    logic [31:0] dly_cnt_q;
    logic begin_q;
    wire btn_hit = btn_wait_q && sdi_s && !sen_s;
    wire dly_hit = dly_wait_q && (dly_cnt_q == 32'h0000_0000);
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i || do_reset || do_stop)
        begin
            btn_wait_q <= 1'b0;
            dly_wait_q <= 1'b0;
            dly_cnt_q <= 32'h0000_0000;
            begin_q <= 1'b0;
        end
        else if (do_start)
        begin
            btn_wait_q <= delay_mode_i;
            dly_wait_q <= !delay_mode_i && fixed_delay_en_i;
            dly_cnt_q <= log_delay_cycles_i;
            begin_q <= !delay_mode_i && !fixed_delay_en_i;
        end
        else
        begin
            begin_q <= btn_hit || dly_hit;
            if (btn_hit)
                btn_wait_q <= 1'b0;
            if (dly_hit)
                dly_wait_q <= 1'b0;
            else if (dly_wait_q)
                dly_cnt_q <= dly_cnt_q - 32'h0000_0001;
        end
    end
    assign logging_begin_o = begin_q;
    // Excitation pad: alarm or sensor supply
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            excitation_pad_o <= 1'b0;
            excitation_pad_oe_o <= 1'b0;
        end
        else if (sensor_supply_select_i)
        begin
            excitation_pad_o <= sensor_conv_active_i;
            excitation_pad_oe_o <= sensor_conv_active_i;
        end
        else
        begin
            excitation_pad_o <= shelf_algo_en_i && shelf_expired_i;
            excitation_pad_oe_o <= shelf_algo_en_i && shelf_expired_i;
        end
    end
    // Fixed priority memory grant
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
            mem_grant_o <= 3'h0;
        else
        begin
            mem_grant_o[GNT_RADIO] <= rf_mem_req_i && !spi_owns;
            mem_grant_o[GNT_LOGGER] <= log_mem_req_i && !(rf_mem_req_i && !spi_owns);
            mem_grant_o[GNT_SERIAL] <= spi_mem_req_i && spi_owns && !rf_mem_req_i
                && !log_mem_req_i;
        end
    end
endmodule

/* tb/spi_direct_command_fifo_props.sv */
// Port checker for the serial direct command interpreter.
module spi_direct_command_fifo_props
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic reset_i,
    // Watched ports
    input wire logic serial_select_i,
    input wire logic conversion_done_out_o,
    input wire logic por_reload_o,
    input wire logic log_start_o,
    input wire logic log_stop_o,
    input wire logic shelf_algo_en_i,
    input wire logic shelf_expired_i,
    input wire logic sensor_supply_select_i,
    input wire logic excitation_pad_o,
    input wire logic excitation_pad_oe_o,
    input wire logic rf_access_cmd_i,
    input wire logic rf_error_o,
    input wire logic [7:0] fifo_state_byte_o,
    input wire logic rf_mem_req_i,
    input wire logic [2:0] mem_grant_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (reset_i);
    // Command pulses last one cycle
    chk_reload_pulse: assert property (por_reload_o |=> !por_reload_o)
        else $error("reload pulse too long");
    chk_start_pulse: assert property (log_start_o |=> !log_start_o)
        else $error("start pulse too long");
    chk_stop_pulse: assert property (log_stop_o |=> !log_stop_o)
        else $error("stop pulse too long");
    // Status and radio side
    chk_empty_flag: assert property (
        fifo_state_byte_o[5] == (fifo_state_byte_o[3:0] == 4'h0)) else $error("no data flag");
    chk_rf_error: assert property (rf_error_o |-> $past(rf_access_cmd_i))
        else $error("radio error without command");
    // Data out rests low between frames
    chk_idle_low: assert property (!serial_select_i [*5] |-> !conversion_done_out_o)
        else $error("data out high outside frame");
    // Alarm on expiry, radio first at the memory
    chk_alarm_drive: assert property (
        (shelf_algo_en_i && shelf_expired_i && !sensor_supply_select_i) [*2]
        |-> excitation_pad_o && excitation_pad_oe_o) else $error("alarm not driven");
    chk_radio_first: assert property (
        (rf_mem_req_i && !serial_select_i) [*4] |=> mem_grant_o == 3'h1)
        else $error("radio not granted first");
endmodule

bind spi_direct_command_fifo spi_direct_command_fifo_props u_props (.core_clk_i, .reset_i,
    .serial_select_i, .conversion_done_out_o, .por_reload_o, .log_start_o, .log_stop_o,
    .shelf_algo_en_i, .shelf_expired_i, .sensor_supply_select_i, .excitation_pad_o,
    .excitation_pad_oe_o, .rf_access_cmd_i, .rf_error_o, .fifo_state_byte_o, .rf_mem_req_i,
    .mem_grant_o);

/* tb/spi_master_model.sv */
// Serial master model: select, still clock between frames, data MSB first.
module spi_master_model
(
    // Serial pins
    input wire logic sdo_i,
    output logic serial_select_o = 1'b0,
    output logic sclk_o = 1'b0,
    output logic sdi_o = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    // Select change with settle time either side
    task automatic sel(input logic v);
        #200 serial_select_o = v;
        #200;
    endtask
    // Shift n bits, answer sampled just before the next rise
    task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
        rx = '0;
        for (int i = n - 1; i >= 0; i--)
        begin
            sdi_o = tx[i];
            #10 sclk_o = 1'b1;
            #80 sclk_o = 1'b0;
            #70 rx = {rx[30:0], sdo_i};
        end
        sdi_o = 1'b0;
    endtask
    // Bounded wait for the done level on data out
    task automatic wait_done(output logic ok);
        ok = 1'b0;
        for (int i = 0; i < 200 && !ok; i++)
            #20 ok = sdo_i;
    endtask
    // Push button on the data input pad
    task automatic press(input logic v);
        sdi_o = v;
    endtask
endmodule

/* tb/spi_direct_command_fifo_tb_top.sv */
// Self-checking bench for the serial direct command interpreter.
module spi_direct_command_fifo_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import spi_cmd_pkg::*;
    logic core_clk_i = '0, reset_i = '1, conv_done_i = '0, delay_mode_i = '0;
    logic fixed_delay_en_i = '0, shelf_algo_en_i = '0, shelf_expired_i = '0;
    logic sensor_supply_select_i = '0, sensor_conv_active_i = '0, rf_fifo_active_i = '0;
    logic rf_access_cmd_i = '0, rf_fifo_wr_i = '0, rf_fifo_rd_i = '0, rf_mem_req_i = '0;
    logic log_mem_req_i = '0, spi_mem_req_i = '0, ok;
    logic [9:0] conv_result_i = '0;
    logic [31:0] log_delay_cycles_i = '0, rx;
    logic [23:0] shelf_life_i = '0;
    logic [7:0] rf_fifo_wdata_i = '0, rf_fifo_rdata_o, fifo_state_byte_o;
    logic serial_select_i, sclk_i, sdi_i, conversion_done_out_o, por_reload_o, conv_start_o;
    logic log_start_o, log_stop_o, logging_begin_o, excitation_pad_o, excitation_pad_oe_o;
    logic rf_error_o;
    logic [1:0] conv_sel_o;
    logic [2:0] mem_grant_o;
    int bad_count = 0, total_checks = 0;
    int n_por = 0, n_start = 0, n_stop = 0, n_begin = 0, n_err = 0;
    // Design and serial master
    spi_direct_command_fifo uut (.core_clk_i, .reset_i, .serial_select_i, .sclk_i, .sdi_i,
        .conversion_done_out_o, .por_reload_o, .conv_start_o, .conv_sel_o, .conv_done_i,
        .conv_result_i, .delay_mode_i, .fixed_delay_en_i, .log_delay_cycles_i, .log_start_o,
        .log_stop_o, .logging_begin_o, .shelf_life_i, .shelf_algo_en_i, .shelf_expired_i,
        .sensor_supply_select_i, .sensor_conv_active_i, .excitation_pad_o, .excitation_pad_oe_o,
        .rf_fifo_active_i, .rf_access_cmd_i, .rf_fifo_wr_i, .rf_fifo_wdata_i, .rf_fifo_rd_i,
        .rf_fifo_rdata_o, .fifo_state_byte_o, .rf_error_o, .rf_mem_req_i, .log_mem_req_i,
        .spi_mem_req_i, .mem_grant_o);
    spi_master_model mst (.sdo_i(conversion_done_out_o), .serial_select_o(serial_select_i),
        .sclk_o(sclk_i), .sdi_o(sdi_i));
    // 50 MHz core clock
    always #10 core_clk_i = ~core_clk_i;
    // Pulse counters; converter done holds until the frame closes
    always @(posedge core_clk_i)
    begin
        n_por += por_reload_o;
        n_start += log_start_o;
        n_stop += log_stop_o;
        n_begin += logging_begin_o;
        n_err += rf_error_o;
        conv_done_i <= #1 conv_start_o | (conv_done_i & serial_select_i);
    end
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
        tick(3);
    endtask
    task automatic end_of_test();
        if (bad_count == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Whole direct command frame, answer left in rx
    task automatic frame(input logic [5:0] c, input logic [31:0] tx, input int n, input logic w);
        mst.sel(1'b1);
        mst.xfer({24'h0, MODE_DIRECT, c}, 8, rx);
        if (w)
        begin
            mst.wait_done(ok);
            chk("done", ok, 1'b1);
        end
        if (n > 0)
            mst.xfer(tx, n, rx);
        mst.sel(1'b0);
    endtask
    // Watchdog for a hung run
    initial
    begin
        #1ms;
        bad_count++;
        end_of_test();
    end
    // Main sequence
    initial
    begin
        tick(12);
        reset_i = 1'b0;
        tick(3);
        chk("reset", fifo_state_byte_o, STATUS_RESET);
        frame(CMD_WRITE_FIFO, 24'hA1_B2C3, 24, 1'b0);
        chk("wr", fifo_state_byte_o, 8'h43);
        frame(CMD_FIFO_STATUS, '0, 8, 1'b0);
        chk("stat", rx, 8'h43);
        chk("head", rf_fifo_rdata_o, 8'hA1);
        pulse(rf_fifo_rd_i);
        chk("pop", rf_fifo_rdata_o, 8'hB2);
        frame(CMD_READ_FIFO, '0, 24, 1'b0);
        chk("rd", rx, 24'hB2_C300);
        chk("empty", fifo_state_byte_o, 8'h20);
        rf_fifo_wr_i = 1'b1;
        for (int i = 1; i < 10; i++)
        begin
            rf_fifo_wdata_i = 8'h10 + 8'(i);
            tick(1);
        end
        rf_fifo_wr_i = 1'b0;
        tick(2);
        chk("full", fifo_state_byte_o, 8'h58);
        mst.sel(1'b1);
        mst.xfer({24'h0, MODE_DIRECT, CMD_READ_FIFO}, 8, rx);
        mst.xfer('0, 32, rx);
        chk("rd_hi", rx, 32'h1112_1314);
        mst.xfer('0, 32, rx);
        chk("rd_lo", rx, 32'h1516_1718);
        pulse(rf_access_cmd_i);
        mst.sel(1'b0);
        pulse(rf_access_cmd_i);
        chk("rf_err", n_err, 1);
        rf_fifo_active_i = 1'b1;
        frame(CMD_FIFO_STATUS, '0, 8, 1'b0);
        chk("busy", rx, 8'hFF);
        rf_fifo_active_i = 1'b0;
        for (int c = 1; c < 5; c++)
        begin
            conv_result_i = 10'h2C0 + 10'(c);
            frame(6'(c), '0, 16, 1'b1);
            chk("conv", rx, 32'(conv_result_i));
            chk("sel", conv_sel_o, c - 1);
        end
        shelf_life_i = 24'h5A_C396;
        frame(CMD_SHELF_LIFE, '0, 24, 1'b0);
        chk("shelf", rx, 32'(shelf_life_i));
        frame(CMD_START_LOG, '0, 0, 1'b0);
        chk("start", n_start, 1);
        chk("begin", n_begin, 1);
        frame(CMD_STOP_LOG, '0, 0, 1'b0);
        chk("stop", n_stop, 1);
        fixed_delay_en_i = 1'b1;
        log_delay_cycles_i = 32'h0000_0064;
        frame(CMD_START_LOG, '0, 0, 1'b0);
        chk("early", n_begin, 1);
        tick(100);
        chk("late", n_begin, 2);
        fixed_delay_en_i = 1'b0;
        delay_mode_i = 1'b1;
        frame(CMD_START_LOG, '0, 0, 1'b0);
        tick(20);
        chk("wait", n_begin, 2);
        mst.press(1'b1);
        tick(5);
        mst.press(1'b0);
        chk("button", n_begin, 3);
        delay_mode_i = 1'b0;
        frame(CMD_WRITE_FIFO, 8'h5E, 8, 1'b0);
        frame(6'h3F, '0, 8, 1'b0);
        chk("unknown", fifo_state_byte_o, 8'h41);
        frame(CMD_RESET, '0, 0, 1'b0);
        chk("por", n_por, 1);
        chk("flush", fifo_state_byte_o, STATUS_RESET);
        shelf_algo_en_i = 1'b1;
        shelf_expired_i = 1'b1;
        tick(3);
        chk("alarm", {excitation_pad_o, excitation_pad_oe_o}, 2'b11);
        sensor_supply_select_i = 1'b1;
        tick(3);
        chk("supply", excitation_pad_o, 1'b0);
        sensor_conv_active_i = 1'b1;
        tick(3);
        chk("excite", {excitation_pad_o, excitation_pad_oe_o}, 2'b11);
        rf_mem_req_i = 1'b1;
        log_mem_req_i = 1'b1;
        spi_mem_req_i = 1'b1;
        tick(6);
        chk("g_rf", mem_grant_o, 3'h1);
        rf_mem_req_i = 1'b0;
        tick(3);
        chk("g_log", mem_grant_o, 3'h2);
        log_mem_req_i = 1'b0;
        mst.sel(1'b1);
        chk("g_spi", mem_grant_o, 3'h4);
        mst.sel(1'b0);
        end_of_test();
    end
endmodule
